//--- design/tsm_pkg.sv
// Constants for the trigger source mask block: register offsets, bit positions,
// reset values and capability defaults.
// Assumes every user writes package::name; nothing is imported.
package tsm_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CHAN_N = 32;

  // Register offsets, as register numbers
  localparam logic [15:0] GENERAL_OR_CAPABILITY_ADDR = 16'h9dd0;
  localparam logic [15:0] GENERAL_OR_SELECT_ADDR = 16'h9dda;
  localparam logic [15:0] AND_MASK_CAPABILITY_ADDR = 16'h9de4;
  localparam logic [15:0] GENERAL_AND_SELECT_ADDR = 16'h9dee;
  localparam logic [15:0] CHANNEL_OR_CAPABILITY_ADDR = 16'h9e02;
  localparam logic [15:0] CHANNEL_OR_SELECT_ADDR = 16'h9e0c;
  localparam logic [15:0] CHANNEL_AND_CAPABILITY_ADDR = 16'h9e16;
  localparam logic [15:0] CHANNEL_AND_SELECT_ADDR = 16'h9e20;

  // Source bit positions in the general masks
  localparam int unsigned SOFTWARE_SOURCE_BIT = 0;
  localparam int unsigned EXTERNAL_INPUT0_BIT = 1;
  localparam int unsigned CHASSIS_LINE0_BIT = 20;
  localparam int unsigned CHASSIS_LINE7_BIT = 27;
  localparam int unsigned CHASSIS_STAR_BIT = 28;
  localparam int unsigned CHASSIS_DIFF_STAR_B_BIT = 29;
  localparam int unsigned CHASSIS_LINE_N = 8;

  localparam logic [31:0] NO_SOURCE_VALUE = 32'h0000_0000;
  localparam logic [31:0] GENERAL_OR_RESET = 32'h0000_0001;
  localparam logic [31:0] GENERAL_AND_RESET = 32'h0000_0000;
  localparam logic [31:0] CHANNEL_OR_RESET = 32'h0000_0000;
  localparam logic [31:0] CHANNEL_AND_RESET = 32'h0000_0000;

  // Capability defaults: software (OR only), ext0, chassis lines, star, diff star B
  localparam logic [31:0] GENERAL_OR_CAP_DEFAULT = 32'h3ff0_0003;
  localparam logic [31:0] GENERAL_AND_CAP_DEFAULT = 32'h3ff0_0002;
  localparam logic [31:0] CHANNEL_CAP_DEFAULT = 32'hffff_ffff;
endpackage

//--- design/tsm_or_stage.sv
// OR stage of the trigger masks: any enabled source whose condition holds.
// Assumes conditions are on the same clock as the caller.
`timescale 1ns/1ns
`default_nettype none
module tsm_or_stage #(
  parameter int unsigned WIDTH = 64
) (
  input wire logic [WIDTH-1:0] mask,
  input wire logic [WIDTH-1:0] cond,
  output logic hit
);
  logic [WIDTH-1:0] sel;

  // One enable bit per source
  assign sel = mask & cond;
  // Empty mask passes true so the AND that follows is not blocked
  assign hit = (mask == '0) | (|sel);
endmodule
`default_nettype wire

//--- design/tsm_and_stage.sv
// AND stage of the trigger masks: all enabled sources must hold together.
// Assumes conditions are on the same clock as the caller.
`timescale 1ns/1ns
`default_nettype none
module tsm_and_stage #(
  parameter int unsigned WIDTH = 64
) (
  input wire logic [WIDTH-1:0] mask,
  input wire logic [WIDTH-1:0] cond,
  output logic hit
);
  logic [WIDTH-1:0] ok;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // Unselected sources never block
      assign ok[i] = ~mask[i] | cond[i];
    end
  endgenerate

  // An empty mask makes ok all ones here, hence true
  assign hit = &ok;
endmodule
`default_nettype wire

//--- design/tsm_trigger_masks.sv
// Top of the trigger source masks: mask registers, capability registers,
// OR and AND stages and the registered trigger output.
// Assumes source conditions and register port are on sys_clk.
//
// What this block does
// - After reset the general OR mask holds only the software source.
// - Bit 0 of the general OR mask selects the software trigger, firing right after arming.
// - A 32-bit read/write channel OR mask enables data channel n with bit n.
// - A read-only channel OR capability mask shows which channels can be used.
// - Each mask holds one bit per source so any mix is set with one write.
// - A mask with nothing enabled yields true; the two OR masks do so only when both are empty.
// - The AND stage is a general AND mask plus a separate channel AND mask.
// - Every source but the software trigger has an AND bit; software has none.
// - The general AND mask is read/write, zero selects nothing and bit 1 is external input 0.
// - Chassis lines 0 to 7 sit at bits 20 to 27 of the general AND mask.
// - Chassis star sits at bit 28 and differential star B at bit 29.
// - A read-only general AND capability mask shows the available sources.
// - Data lines join pattern matching through a channel AND mask, one bit per channel.
`timescale 1ns/1ns
`default_nettype none
module tsm_trigger_masks #(
  parameter logic [31:0] GENERAL_OR_CAP = tsm_pkg::GENERAL_OR_CAP_DEFAULT,
  parameter logic [31:0] GENERAL_AND_CAP = tsm_pkg::GENERAL_AND_CAP_DEFAULT,
  parameter logic [31:0] CHANNEL_OR_CAP = tsm_pkg::CHANNEL_CAP_DEFAULT,
  parameter logic [31:0] CHANNEL_AND_CAP = tsm_pkg::CHANNEL_CAP_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  input wire logic trigger_armed,
  input wire logic [31:0] data_line_cond,
  input wire logic external_input0_cond,
  input wire logic [7:0] chassis_line_cond,
  input wire logic chassis_star_cond,
  input wire logic chassis_diff_star_b_cond,
  output logic trigger_out,
  output logic or_stage_hit,
  output logic and_stage_hit
);
  logic rst_meta_q;
  logic rst_sync_q;
  logic [31:0] general_or_select_q;
  logic [31:0] general_and_select_q;
  logic [31:0] channel_or_select_q;
  logic [31:0] channel_and_select_q;
  logic [31:0] reg_rdata_q;
  logic [31:0] reg_rdata_d;
  logic reg_ack_q;
  logic trigger_q;
  logic trigger_d;
  logic or_hit_q;
  logic and_hit_q;
  logic [31:0] general_cond;
  logic [31:0] gen_or_live;
  logic [31:0] gen_and_live;
  logic [31:0] chan_or_live;
  logic [31:0] chan_and_live;
  logic or_hit;
  logic and_hit;
  logic software_selected;

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Per-source conditions in general mask layout
  always_comb begin
    general_cond = tsm_pkg::NO_SOURCE_VALUE;
    general_cond[tsm_pkg::SOFTWARE_SOURCE_BIT] = trigger_armed;
    general_cond[tsm_pkg::EXTERNAL_INPUT0_BIT] = external_input0_cond;
    general_cond[tsm_pkg::CHASSIS_LINE7_BIT:tsm_pkg::CHASSIS_LINE0_BIT] = chassis_line_cond;
    general_cond[tsm_pkg::CHASSIS_STAR_BIT] = chassis_star_cond;
    general_cond[tsm_pkg::CHASSIS_DIFF_STAR_B_BIT] = chassis_diff_star_b_cond;
  end

  // Mask registers; writes keep only implemented bits
  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      general_or_select_q <= tsm_pkg::GENERAL_OR_RESET;
      general_and_select_q <= tsm_pkg::GENERAL_AND_RESET;
      channel_or_select_q <= tsm_pkg::CHANNEL_OR_RESET;
      channel_and_select_q <= tsm_pkg::CHANNEL_AND_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        tsm_pkg::GENERAL_OR_SELECT_ADDR: begin
          general_or_select_q <= reg_wdata & GENERAL_OR_CAP;
        end
        tsm_pkg::GENERAL_AND_SELECT_ADDR: begin
          general_and_select_q <= reg_wdata & GENERAL_AND_CAP;
        end
        tsm_pkg::CHANNEL_OR_SELECT_ADDR: begin
          channel_or_select_q <= reg_wdata & CHANNEL_OR_CAP;
        end
        tsm_pkg::CHANNEL_AND_SELECT_ADDR: begin
          channel_and_select_q <= reg_wdata & CHANNEL_AND_CAP;
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      tsm_pkg::GENERAL_OR_CAPABILITY_ADDR: reg_rdata_d = GENERAL_OR_CAP;
      tsm_pkg::GENERAL_OR_SELECT_ADDR: reg_rdata_d = general_or_select_q;
      tsm_pkg::AND_MASK_CAPABILITY_ADDR: reg_rdata_d = GENERAL_AND_CAP;
      tsm_pkg::GENERAL_AND_SELECT_ADDR: reg_rdata_d = general_and_select_q;
      tsm_pkg::CHANNEL_OR_CAPABILITY_ADDR: reg_rdata_d = CHANNEL_OR_CAP;
      tsm_pkg::CHANNEL_OR_SELECT_ADDR: reg_rdata_d = channel_or_select_q;
      tsm_pkg::CHANNEL_AND_CAPABILITY_ADDR: reg_rdata_d = CHANNEL_AND_CAP;
      tsm_pkg::CHANNEL_AND_SELECT_ADDR: reg_rdata_d = channel_and_select_q;
      default: reg_rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      reg_rdata_q <= 32'h0000_0000;
      reg_ack_q <= 1'b0;
    end else begin
      reg_ack_q <= reg_rd | reg_wr;
      if (reg_rd) begin
        reg_rdata_q <= reg_rdata_d;
      end
    end
  end

  // Capability gating again, in case of a narrower capability at build
  assign gen_or_live = general_or_select_q & GENERAL_OR_CAP;
  assign gen_and_live = general_and_select_q & GENERAL_AND_CAP &
    ~(32'h0000_0001 << tsm_pkg::SOFTWARE_SOURCE_BIT);
  assign chan_or_live = channel_or_select_q & CHANNEL_OR_CAP;
  assign chan_and_live = channel_and_select_q & CHANNEL_AND_CAP;
  assign software_selected = gen_or_live[tsm_pkg::SOFTWARE_SOURCE_BIT];

  // Software source left out of the OR stage; it bypasses it below
  tsm_or_stage #(
    .WIDTH(64)
  ) u_or_stage (
    .mask({chan_or_live, gen_or_live & ~(32'h0000_0001 << tsm_pkg::SOFTWARE_SOURCE_BIT)}),
    .cond({data_line_cond, general_cond}),
    .hit(or_hit)
  );

  // General AND plus channel AND mask
  tsm_and_stage #(
    .WIDTH(64)
  ) u_and_stage (
    .mask({chan_and_live, gen_and_live}),
    .cond({data_line_cond, general_cond}),
    .hit(and_hit)
  );

  // Software source dominates everything once armed
  assign trigger_d = trigger_armed & (software_selected | (or_hit & and_hit));

  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      trigger_q <= 1'b0;
      or_hit_q <= 1'b0;
      and_hit_q <= 1'b0;
    end else begin
      trigger_q <= trigger_d;
      or_hit_q <= or_hit;
      and_hit_q <= and_hit;
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign reg_ack = reg_ack_q;
  assign trigger_out = trigger_q;
  assign or_stage_hit = or_hit_q;
  assign and_stage_hit = and_hit_q;

  property p_or_default;
    @(posedge sys_clk) disable iff (!rst_sync_q)
      $rose(rst_sync_q) |-> general_or_select_q == tsm_pkg::GENERAL_OR_RESET;
  endproperty
  a_or_default: assert property (p_or_default) else $error("OR mask not software after reset");

  property p_sw_fires;
    @(posedge sys_clk) disable iff (!rst_sync_q)
      (trigger_armed && general_or_select_q[0] && (GENERAL_OR_CAP[0] == 1'b1)) |=> trigger_q;
  endproperty
  a_sw_fires: assert property (p_sw_fires) else $error("software source did not fire");

  property p_no_sw_and;
    @(posedge sys_clk) disable iff (!rst_sync_q)
      reg_wr && reg_addr == tsm_pkg::GENERAL_AND_SELECT_ADDR |=> !general_and_select_q[0];
  endproperty
  a_no_sw_and: assert property (p_no_sw_and) else $error("software bit stored in AND mask");

  property p_chan_or_write;
    @(posedge sys_clk) disable iff (!rst_sync_q)
      reg_wr && reg_addr == tsm_pkg::CHANNEL_OR_SELECT_ADDR |=>
        channel_or_select_q == ($past(reg_wdata) & CHANNEL_OR_CAP);
  endproperty
  a_chan_or_write: assert property (p_chan_or_write) else $error("channel OR mask write lost");

  property p_empty_true;
    @(posedge sys_clk) disable iff (!rst_sync_q)
      (trigger_armed && general_or_select_q == '0 && general_and_select_q == '0 &&
        channel_or_select_q == '0 && channel_and_select_q == '0) |=> trigger_q;
  endproperty
  a_empty_true: assert property (p_empty_true) else $error("empty masks blocked trigger");

  property p_and_blocks_ext;
    @(posedge sys_clk) disable iff (!rst_sync_q)
      (!general_or_select_q[0] && general_and_select_q[1] && !external_input0_cond) |=> !trigger_q;
  endproperty
  a_and_blocks_ext: assert property (p_and_blocks_ext) else $error("ext0 AND bit did not gate");

  property p_and_blocks_chassis;
    @(posedge sys_clk) disable iff (!rst_sync_q)
      (!general_or_select_q[0] && general_and_select_q[20] && !chassis_line_cond[0]) |=> !trigger_q;
  endproperty
  a_and_blocks_chassis: assert property (p_and_blocks_chassis) else $error("chassis line 0 did not gate");

  property p_and_blocks_star;
    @(posedge sys_clk) disable iff (!rst_sync_q)
      (!general_or_select_q[0] && general_and_select_q[28] && !chassis_star_cond) |=> !trigger_q;
  endproperty
  a_and_blocks_star: assert property (p_and_blocks_star) else $error("star line did not gate");

  property p_chan_and_blocks;
    @(posedge sys_clk) disable iff (!rst_sync_q)
      (!general_or_select_q[0] && channel_and_select_q[3] && !data_line_cond[3]) |=> !trigger_q;
  endproperty
  a_chan_and_blocks: assert property (p_chan_and_blocks) else $error("channel AND bit did not gate");

  property p_and_cap_read;
    @(posedge sys_clk) disable iff (!rst_sync_q)
      reg_rd && reg_addr == tsm_pkg::AND_MASK_CAPABILITY_ADDR |=> reg_ack_q && reg_rdata_q == GENERAL_AND_CAP;
  endproperty
  a_and_cap_read: assert property (p_and_cap_read) else $error("AND capability read wrong");

  property p_chan_cap_read;
    @(posedge sys_clk) disable iff (!rst_sync_q)
      reg_rd && reg_addr == tsm_pkg::CHANNEL_OR_CAPABILITY_ADDR |=> reg_rdata_q == CHANNEL_OR_CAP;
  endproperty
  a_chan_cap_read: assert property (p_chan_cap_read) else $error("channel OR capability read wrong");

  property p_unarmed_quiet;
    @(posedge sys_clk) disable iff (!rst_sync_q)
      !trigger_armed |=> !trigger_q;
  endproperty
  a_unarmed_quiet: assert property (p_unarmed_quiet) else $error("trigger while not armed");

  property p_cap_gate;
    @(posedge sys_clk) disable iff (!rst_sync_q)
      (general_and_select_q & ~GENERAL_AND_CAP) == '0 && (channel_or_select_q & ~CHANNEL_OR_CAP) == '0;
  endproperty
  a_cap_gate: assert property (p_cap_gate) else $error("unimplemented mask bit stored");

  property p_and_blocks_diff_star;
    @(posedge sys_clk) disable iff (!rst_sync_q)
      (!general_or_select_q[0] && general_and_select_q[29] && !chassis_diff_star_b_cond) |=> !trigger_q;
  endproperty
  a_and_blocks_diff_star: assert property (p_and_blocks_diff_star) else $error("diff star B did not gate");

  property p_chan_or_fires;
    @(posedge sys_clk) disable iff (!rst_sync_q)
      (trigger_armed && channel_or_select_q[0] && data_line_cond[0] && and_hit) |=> trigger_q;
  endproperty
  a_chan_or_fires: assert property (p_chan_or_fires) else $error("channel OR source did not fire");

  property p_chan_and_write;
    @(posedge sys_clk) disable iff (!rst_sync_q)
      reg_wr && reg_addr == tsm_pkg::CHANNEL_AND_SELECT_ADDR |=>
        channel_and_select_q == ($past(reg_wdata) & CHANNEL_AND_CAP);
  endproperty
  a_chan_and_write: assert property (p_chan_and_write) else $error("channel AND mask write lost");

  property p_access_ack;
    @(posedge sys_clk) disable iff (!rst_sync_q)
      (reg_wr || reg_rd) |=> reg_ack_q;
  endproperty
  a_access_ack: assert property (p_access_ack) else $error("register access not answered");

  c_sw_trigger: cover property (@(posedge sys_clk) disable iff (!rst_sync_q)
    trigger_armed && software_selected ##1 trigger_q);
  c_ext_or: cover property (@(posedge sys_clk) disable iff (!rst_sync_q)
    !software_selected && gen_or_live[1] && external_input0_cond && trigger_armed ##1 trigger_q);
  c_pattern: cover property (@(posedge sys_clk) disable iff (!rst_sync_q)
    !software_selected && chan_and_live[3:0] == 4'hf && and_hit && trigger_armed ##1 trigger_q);
  c_cap_read: cover property (@(posedge sys_clk) disable iff (!rst_sync_q)
    reg_rd && reg_addr == tsm_pkg::AND_MASK_CAPABILITY_ADDR ##1 reg_ack_q);
endmodule
`default_nettype wire

//--- sim/tsm_host_model.sv
// Host software model: turns one bench request into a one-cycle register strobe.
// Assumes reg_ack comes one cycle after each strobe, as the register port promises.
`timescale 1ns/1ns
`default_nettype none
module tsm_host_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic wr,
  input wire logic [15:0] addr,
  input wire logic [31:0] wdata,
  output logic done,
  output logic [31:0] rdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_addr,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack
);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= 16'h0000;
      reg_wdata <= 32'h0000_0000;
      done <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      reg_wr <= go & wr; // Whole source set in one write
      reg_rd <= go & ~wr;
      // Idle bus inverts each cycle, so every other cycle shows the last value
      reg_addr <= go ? addr : ~reg_addr;
      reg_wdata <= go ? wdata : ~reg_wdata;
      done <= reg_ack;
      if (reg_ack) begin
        rdata <= reg_rdata;
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/tsm_trigger_masks_tb.sv
// Self-checking bench for the trigger source masks, random with corner cases.
// Assumes the design defaults for all capability parameters.
`timescale 1ns/1ns
`default_nettype none
module tsm_trigger_masks_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic wr = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic done, reg_wr, reg_rd, reg_ack, trigger_out, or_stage_hit, and_stage_hit;
  logic [15:0] reg_addr;
  logic [31:0] rdata, reg_wdata, reg_rdata, rd;
  logic trigger_armed = 1'b0;
  logic [31:0] data_line_cond = 32'h0000_0000;
  logic [31:0] gc = 32'h0000_0000;
  logic [31:0] gor = 32'h0000_0001, gand = 32'h0000_0000, cor = 32'h0000_0000, cand = 32'h0000_0000;
  logic [15:0] tbl [4] = '{tsm_pkg::GENERAL_OR_SELECT_ADDR, tsm_pkg::GENERAL_AND_SELECT_ADDR,
    tsm_pkg::CHANNEL_OR_SELECT_ADDR, tsm_pkg::CHANNEL_AND_SELECT_ADDR};
  int errors = 0;
  int n_tests = 0;
  always #4 sys_clk = ~sys_clk;
  tsm_host_model tsm_host_model_inst (.sys_clk(sys_clk), .rst_n(rst_n), .go(go), .wr(wr), .addr(addr),
    .wdata(wdata), .done(done), .rdata(rdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack));
  tsm_trigger_masks tsm_trigger_masks_inst (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .trigger_armed(trigger_armed), .data_line_cond(data_line_cond), .external_input0_cond(gc[1]),
    .chassis_line_cond(gc[27:20]), .chassis_star_cond(gc[28]), .chassis_diff_star_b_cond(gc[29]),
    .trigger_out(trigger_out), .or_stage_hit(or_stage_hit), .and_stage_hit(and_stage_hit));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge sys_clk);
    #1;
    go = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    @(posedge sys_clk);
    #1;
    go = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 10) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    check("register answer", {31'h0, done}, 32'h1);
    r = rdata;
  endtask
  task automatic wreg(input logic [15:0] a, input logic [31:0] d);
    acc(1'b1, a, d, rd);
    if (a == tbl[0]) gor = d;
    if (a == tbl[1]) gand = d;
    if (a == tbl[2]) cor = d;
    if (a == tbl[3]) cand = d;
  endtask
  function automatic logic [2:0] exp_f(input logic arm, input logic [31:0] dl, input logic [31:0] g);
    logic [31:0] o, a;
    logic oh, ah;
    o = gor & tsm_pkg::GENERAL_OR_CAP_DEFAULT;
    a = gand & tsm_pkg::GENERAL_AND_CAP_DEFAULT;
    oh = ((o & 32'hffff_fffe) == 32'h0 && cor == 32'h0) || |(o & g & 32'hffff_fffe) || |(cor & dl);
    ah = ((a & g) == a) && ((cand & dl) == cand);
    return {arm & (o[0] | (oh & ah)), oh, ah};
  endfunction
  task automatic apply(input logic arm, input logic [31:0] dl, input logic [31:0] g);
    logic [2:0] e;
    @(posedge sys_clk);
    #1;
    trigger_armed = arm;
    data_line_cond = dl;
    gc = g;
    e = exp_f(arm, dl, g);
    @(posedge sys_clk);
    #1;
    check("trigger_out", {31'h0, trigger_out}, {31'h0, e[2]});
    if (arm) begin
      check("or_stage_hit", {31'h0, or_stage_hit}, {31'h0, e[1]});
      check("and_stage_hit", {31'h0, and_stage_hit}, {31'h0, e[0]});
    end
  endtask
  task automatic rchk(input string name, input logic [15:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0000_0000, rd);
    check(name, rd, exp);
  endtask
  initial begin
    #(8 * 25000);
    errors++;
    $display("watchdog expired");
    stop_test();
  end
  initial begin
    int k;
    logic [31:0] v;
    void'($urandom(44));
    repeat (16) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    rchk("or select reset", tbl[0], tsm_pkg::GENERAL_OR_RESET);
    rchk("and select reset", tbl[1], tsm_pkg::NO_SOURCE_VALUE);
    rchk("channel or reset", tbl[2], 32'h0000_0000);
    wreg(tsm_pkg::AND_MASK_CAPABILITY_ADDR, 32'h0000_0000);
    rchk("and capability", tsm_pkg::AND_MASK_CAPABILITY_ADDR, tsm_pkg::GENERAL_AND_CAP_DEFAULT);
    rchk("channel or capability", tsm_pkg::CHANNEL_OR_CAPABILITY_ADDR, 32'hffff_ffff);
    rchk("or capability", tsm_pkg::GENERAL_OR_CAPABILITY_ADDR, tsm_pkg::GENERAL_OR_CAP_DEFAULT);
    rchk("channel and capability", tsm_pkg::CHANNEL_AND_CAPABILITY_ADDR, 32'hffff_ffff);
    rchk("unmapped", 16'h1234, 32'h0000_0000);
    apply(1'b1, 32'h0, 32'h0);
    wreg(tbl[1], 32'h0000_0002);
    apply(1'b1, 32'h0, 32'h0);
    wreg(tbl[0], tsm_pkg::NO_SOURCE_VALUE);
    apply(1'b1, 32'h0, 32'h0);
    wreg(tbl[1], 32'h0000_0000);
    apply(1'b1, 32'h0, 32'h0);
    apply(1'b0, 32'h0, 32'h0);
    $display("test reset and software source done");
    wreg(tbl[1], 32'hffff_ffff);
    rchk("and select", tbl[1], tsm_pkg::GENERAL_AND_CAP_DEFAULT);
    wreg(tbl[0], 32'hffff_ffff);
    rchk("or select", tbl[0], tsm_pkg::GENERAL_OR_CAP_DEFAULT);
    wreg(tbl[2], 32'ha5a5_0f0f);
    rchk("channel or", tbl[2], 32'ha5a5_0f0f);
    wreg(tbl[3], 32'h5a5a_f0f0);
    rchk("channel and", tbl[3], 32'h5a5a_f0f0);
    $display("test readback done");
    // Mid-run reset must bring every mask back to its reset value
    @(posedge sys_clk);
    #1;
    rst_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    gor = tsm_pkg::GENERAL_OR_RESET;
    gand = tsm_pkg::GENERAL_AND_RESET;
    cor = tsm_pkg::CHANNEL_OR_RESET;
    cand = tsm_pkg::CHANNEL_AND_RESET;
    repeat (4) @(posedge sys_clk);
    rchk("or select after reset", tbl[0], 32'h0000_0001);
    rchk("and select after reset", tbl[1], 32'h0000_0000);
    rchk("channel or after reset", tbl[2], 32'h0000_0000);
    rchk("channel and after reset", tbl[3], 32'h0000_0000);
    apply(1'b1, 32'h0, 32'h0);
    $display("test mid-run reset done");
    wreg(tbl[0], 32'h0);
    wreg(tbl[2], 32'h0);
    wreg(tbl[3], 32'h0);
    for (int i = 0; i < 11; i++) begin
      v = 32'h1 << ((i == 0) ? 1 : 19 + i);
      wreg(tbl[1], v);
      apply(1'b1, 32'h0, ~v);
      apply(1'b1, 32'h0, 32'hffff_ffff);
    end
    wreg(tbl[1], 32'h0);
    wreg(tbl[2], 32'h8000_0000);
    apply(1'b1, 32'h7fff_ffff, 32'h0);
    apply(1'b1, 32'h8000_0000, 32'h0);
    $display("test source bits done");
    repeat (300) begin
      if ($urandom % 8 == 0) begin
        k = $urandom % 4;
        v = $urandom & $urandom & $urandom;
        wreg(tbl[k], (k == 0) ? (v & 32'hffff_fffe) : v);
      end
      apply(($urandom % 4) != 0, $urandom | $urandom, $urandom | $urandom);
    end
    $display("test random done");
    stop_test();
  end
endmodule
`default_nettype wire
